// *** rtl/t8p_top.sv ***
// Purpose: 8-bit timer pwm waveform unit: counter, compare and pins
// Assumes: timer_tick is a one-cycle enable from an outside prescaler
// Notes:   normal and ctc modes only count up and leave the waves alone

`timescale 1ns/1ps

module t8p_top
  import t8p_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic timer_tick,
  input t8p_bus_t bus,
  output logic [7:0] rdata,
  input wire logic dir_a,
  input wire logic dir_b,
  input wire logic port_a,
  input wire logic port_b,
  output logic chan_a_wave_out,
  output logic chan_a_wave_oe,
  output logic chan_b_wave_out,
  output logic chan_b_wave_oe,
  output logic overflow_flag,
  output logic chan_a_match_flag,
  output logic chan_b_match_flag
);

  // ----------------------------------------------------------------
  // state of the counter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] count; // count_value
    t8p_dir_t dir; // count direction
    logic [7:0] cmp_a; // active chan_a_compare_value
    logic [7:0] cmp_b; // active channel b compare value
    logic block; // match blocked after a count write
  } t8p_top_st_t;

  t8p_top_st_t st_r; // registered state
  t8p_top_st_t st_nxt; // next state

  t8p_cfg_t cfg; // configuration from the register port
  t8p_evt_t evt; // events toward the flags
  logic count_wr; // software writes count_value
  logic [2:0] flags; // flag levels
  logic fast; // single-slope mode
  logic pc; // dual-slope mode
  logic [7:0] top; // current top value
  logic at_top; // tick while count equals top
  logic at_bot; // tick while count equals bottom
  logic match_a; // channel a compare match
  logic match_b; // channel b compare match
  logic up_count; // direction seen by the channels
  logic reload; // active compares take the buffers
  logic from_max_a; // channel a leaves max at this top
  logic from_max_b; // channel b leaves max at this top
  logic wave_a; // channel a wave state
  logic wave_b; // channel b wave state
  logic toggle_a_ok; // toggle allowed for channel a

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // the io-space alias of control a is an address shift done by the
  // core, so only the data-space offset decodes here
  t8p_regs u_regs (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .bus(bus),
    .evt(evt),
    .count_in(st_r.count),
    .rdata(rdata),
    .cfg(cfg),
    .count_wr(count_wr),
    .flags(flags)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // high mode bit joins the low bits from control a
  always_comb begin
    fast = (cfg.wave == T8P_WM_FAST_MAX) || (cfg.wave == T8P_WM_FAST_CMP);
    pc = (cfg.wave == T8P_WM_PC_MAX) || (cfg.wave == T8P_WM_PC_CMP);
    // top from compare a only in the high-bit modes
    top = cfg.wave[2] ? st_r.cmp_a : T8P_MAX;
  end

  // ----------------------------------------------------------------
  // tick qualified comparisons
  // ----------------------------------------------------------------
  // counting and matches move only on a timer tick, the clock itself is free
  always_comb begin
    at_top = timer_tick && (st_r.count == top);
    at_bot = timer_tick && (st_r.count == T8P_BOTTOM);
    // a count write blocks the next tick's match, as intended by software
    match_a = timer_tick && !st_r.block && (st_r.count == st_r.cmp_a);
    match_b = timer_tick && !st_r.block && (st_r.count == st_r.cmp_b);
    // bottom turnaround counts as the start of the up slope
    up_count = (st_r.dir == T8P_UP) || (st_r.count == T8P_BOTTOM);
    toggle_a_ok = cfg.wave[2]; // only with the high mode bit
  end

  // ----------------------------------------------------------------
  // double buffering of the compare values
  // ----------------------------------------------------------------
  // fast updates at bottom (the wrap tick), phase correct at top,
  // other modes take the buffer at once
  always_comb begin
    reload = 1'b0;
    from_max_a = 1'b0;
    from_max_b = 1'b0;
    if (fast || pc) begin
      reload = at_top;
    end else begin
      reload = 1'b1;
    end
    if (pc && at_top) begin
      // leaving max must land on the up-match level for symmetry
      from_max_a = (st_r.cmp_a == T8P_MAX) && (cfg.cmp_a != T8P_MAX);
      from_max_b = (st_r.cmp_b == T8P_MAX) && (cfg.cmp_b != T8P_MAX);
    end
  end

  // ----------------------------------------------------------------
  // counter next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    evt = '0;
    evt.match_a = match_a;
    evt.match_b = match_b;
    if (reload) begin
      st_nxt.cmp_a = cfg.cmp_a;
      st_nxt.cmp_b = cfg.cmp_b;
    end
    if (timer_tick) begin
      st_nxt.block = 1'b0; // blocking lasts for one tick only
    end
    if (count_wr) begin
      // software write wins over counting and arms the match block
      st_nxt.count = bus.wdata;
      st_nxt.block = 1'b1;
    end else if (fast) begin
      st_nxt.dir = T8P_UP;
      if (at_top) begin
        st_nxt.count = T8P_BOTTOM; // wrap on the tick after top
        evt.ovf = 1'b1;
      end else if (timer_tick) begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end else if (pc) begin
      case (st_r.dir)
        T8P_UP: begin
          if (at_top) begin
            // top was held for this one tick, now turn round
            st_nxt.dir = T8P_DOWN;
            if (top != T8P_BOTTOM) begin
              st_nxt.count = st_r.count - 8'h01;
            end
          end else if (timer_tick) begin
            st_nxt.count = st_r.count + 8'h01;
          end
        end
        T8P_DOWN: begin
          if (at_bot) begin
            st_nxt.dir = T8P_UP;
            evt.ovf = 1'b1; // flag at bottom
            if (top != T8P_BOTTOM) begin
              st_nxt.count = st_r.count + 8'h01;
            end
          end else if (timer_tick) begin
            // a lowered top below count still walks down to bottom
            st_nxt.count = st_r.count - 8'h01;
          end
        end
        default: st_nxt.dir = T8P_UP;
      endcase
    end else begin
      // non-pwm modes are outside this unit: plain upward count
      st_nxt.dir = T8P_UP;
      if (timer_tick) begin
        st_nxt.count = st_r.count + 8'h01;
        evt.ovf = (st_r.count == T8P_MAX);
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output compare channels
  // ----------------------------------------------------------------
  t8p_chan u_chan_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .fast(fast),
    .pc(pc),
    .up_count(up_count),
    .at_wrap(fast && at_top),
    .at_top(pc && at_top && st_r.dir == T8P_UP),
    .match(match_a),
    .cmp_is_top(st_r.cmp_a == top),
    .from_max(from_max_a),
    .toggle_ok(toggle_a_ok),
    .om(cfg.om_a),
    .wave(wave_a)
  );

  // channel b has no toggle option
  t8p_chan u_chan_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .fast(fast),
    .pc(pc),
    .up_count(up_count),
    .at_wrap(fast && at_top),
    .at_top(pc && at_top && st_r.dir == T8P_UP),
    .match(match_b),
    .cmp_is_top(st_r.cmp_b == top),
    .from_max(from_max_b),
    .toggle_ok(1'b0),
    .om(cfg.om_b),
    .wave(wave_b)
  );

  // ----------------------------------------------------------------
  // pin override
  // ----------------------------------------------------------------
  // the wave replaces port data once an output mode is set, but the
  // driver only turns on with the direction bit
  always_comb begin
    chan_a_wave_out = (cfg.om_a != T8P_OM_OFF) ? wave_a : port_a;
    chan_b_wave_out = (cfg.om_b != T8P_OM_OFF) ? wave_b : port_b;
    chan_a_wave_oe = dir_a;
    chan_b_wave_oe = dir_b;
  end

  assign overflow_flag = flags[T8P_POS_F_OVF];
  assign chan_a_match_flag = flags[T8P_POS_F_MA];
  assign chan_b_match_flag = flags[T8P_POS_F_MB];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // fast mode returns to bottom right after the top tick
  fast_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fast && at_top && !count_wr ##1 fast |-> st_r.count == T8P_BOTTOM)
    else $error("fast counter did not wrap");

  // fast overflow event exactly with the top tick
  fast_ovf_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fast && at_top && !count_wr |-> evt.ovf)
    else $error("fast overflow not raised at top");

  // phase correct turns down after top, one below
  pc_turn_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pc && at_top && st_r.dir == T8P_UP && top != T8P_BOTTOM && !count_wr
    ##1 pc |-> st_r.dir == T8P_DOWN && st_r.count == $past(st_r.count) - 8'h01)
    else $error("phase correct did not reverse at top");

  // phase correct overflow only at bottom
  pc_ovf_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pc && evt.ovf |-> st_r.count == T8P_BOTTOM && timer_tick)
    else $error("phase correct overflow away from bottom");

  // without a tick or write the counter stands still
  tick_enable_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !timer_tick && !count_wr |=> st_r.count == $past(st_r.count))
    else $error("counter moved without a tick");

  // wrap in fast mode loads the active compare from the buffer
  fast_reload_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fast && at_top && !bus.wr |=> st_r.cmp_a == $past(cfg.cmp_a))
    else $error("compare not reloaded at bottom");

  // pin enable follows the direction bit alone
  pin_dir_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    chan_a_wave_oe == dir_a && chan_b_wave_oe == dir_b)
    else $error("pin enable not from direction");

  // a match is flagged on the very next edge
  match_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    timer_tick && !st_r.block && st_r.count == st_r.cmp_b |=> chan_b_match_flag)
    else $error("channel b match not flagged");

endmodule // t8p_top

// *** pkg/t8p_pkg.sv ***
// Purpose: shared constants and carrier types for the 8-bit pwm waveform unit
// Assumes: one clock (clk_sys), synchronous active-high reset
// Notes:   offsets are data-space byte addresses of the register port

package t8p_pkg;

  // ----------------------------------------------------------------
  // register offsets (data space)
  // ----------------------------------------------------------------
  localparam logic [7:0] T8P_OFF_CTRL_A = 8'h44; // timer_control_a
  localparam logic [7:0] T8P_OFF_CTRL_B = 8'h45; // timer_control_b
  localparam logic [7:0] T8P_OFF_COUNT = 8'h46; // count_value
  localparam logic [7:0] T8P_OFF_CMP_A = 8'h47; // chan_a_compare_value buffer
  localparam logic [7:0] T8P_OFF_CMP_B = 8'h48; // chan_b compare buffer
  localparam logic [7:0] T8P_OFF_FLAGS = 8'h35; // event flags, write one to clear

  // ----------------------------------------------------------------
  // field positions, reset values, counter extremes
  // ----------------------------------------------------------------
  localparam int T8P_POS_OM_A = 6; // chan_a_output_mode lsb
  localparam int T8P_POS_OM_B = 4; // chan_b_output_mode lsb
  localparam int T8P_POS_WAVE = 0; // low wave_mode_select bits lsb
  localparam int T8P_POS_WAVE_HI = 3; // wave_mode_high_bit in timer_control_b
  localparam int T8P_POS_F_OVF = 0; // overflow_flag
  localparam int T8P_POS_F_MA = 1; // chan_a_match_flag
  localparam int T8P_POS_F_MB = 2; // chan_b_match_flag
  localparam logic [7:0] T8P_RST_BYTE = 8'h00; // every register after reset
  localparam logic [7:0] T8P_CTRL_A_MASK = 8'hf3; // bits 3:2 unused, read zero
  localparam logic [7:0] T8P_MAX = 8'hff; // counter max
  localparam logic [7:0] T8P_BOTTOM = 8'h00; // counter bottom

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] T8P_OM_OFF = 2'h0; // port pin keeps its own data
  localparam logic [1:0] T8P_OM_TOGGLE = 2'h1; // toggle on match
  localparam logic [1:0] T8P_OM_NONINV = 2'h2; // non-inverted pwm
  localparam logic [1:0] T8P_OM_INV = 2'h3; // inverted pwm
  localparam logic [2:0] T8P_WM_PC_MAX = 3'h1; // phase correct, top = max
  localparam logic [2:0] T8P_WM_FAST_MAX = 3'h3; // fast, top = max
  localparam logic [2:0] T8P_WM_PC_CMP = 3'h5; // phase correct, top = compare a
  localparam logic [2:0] T8P_WM_FAST_CMP = 3'h7; // fast, top = compare a

  // count direction, gray along up -> down
  typedef enum logic {T8P_UP = 1'b0, T8P_DOWN = 1'b1} t8p_dir_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t8p_bus_t;

  // configuration seen by the counter and channels
  typedef struct packed {
    logic [1:0] om_a;
    logic [1:0] om_b;
    logic [2:0] wave;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
  } t8p_cfg_t;

  // one-cycle events raised by the counter
  typedef struct packed {
    logic ovf;
    logic match_a;
    logic match_b;
  } t8p_evt_t;

endpackage

// *** rtl/t8p_regs.sv ***
// Purpose: register port of the waveform unit, control, buffers and flags
// Assumes: wr and rd are single-cycle strobes synchronous to clk_sys
// Notes:   read data appears on the edge after rd; flags clear on write one

`timescale 1ns/1ps

module t8p_regs
  import t8p_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input t8p_bus_t bus,
  input t8p_evt_t evt,
  input wire logic [7:0] count_in,
  output logic [7:0] rdata,
  output t8p_cfg_t cfg,
  output logic count_wr,
  output logic [2:0] flags
);

  // all state of this module
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [2:0] flags;
    logic [7:0] rdata;
  } t8p_regs_st_t;

  t8p_regs_st_t st_r; // registered state
  t8p_regs_st_t st_nxt; // next state
  logic [2:0] set_vec; // hardware event per flag
  logic [2:0] clr_vec; // software clear per flag

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    set_vec = {evt.match_b, evt.match_a, evt.ovf};
    clr_vec = (bus.wr && bus.addr == T8P_OFF_FLAGS) ? bus.wdata[2:0] : 3'h0;
    if (bus.wr) begin
      case (bus.addr)
        T8P_OFF_CTRL_A: st_nxt.ctrl_a = bus.wdata & T8P_CTRL_A_MASK;
        T8P_OFF_CTRL_B: st_nxt.ctrl_b = bus.wdata; // high mode bit lives here
        T8P_OFF_CMP_A: st_nxt.cmp_a = bus.wdata;
        T8P_OFF_CMP_B: st_nxt.cmp_b = bus.wdata;
        default: st_nxt.ctrl_b = st_r.ctrl_b; // count and flags handled elsewhere
      endcase
    end
    // set wins over a clear in the same cycle, so no event is lost
    st_nxt.flags = (st_r.flags & ~clr_vec) | set_vec;
    if (bus.rd) begin
      case (bus.addr)
        T8P_OFF_CTRL_A: st_nxt.rdata = st_r.ctrl_a;
        T8P_OFF_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
        T8P_OFF_COUNT: st_nxt.rdata = count_in;
        T8P_OFF_CMP_A: st_nxt.rdata = st_r.cmp_a;
        T8P_OFF_CMP_B: st_nxt.rdata = st_r.cmp_b;
        T8P_OFF_FLAGS: st_nxt.rdata = {5'h00, st_r.flags};
        default: st_nxt.rdata = T8P_RST_BYTE; // unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign rdata = st_r.rdata;
  assign flags = st_r.flags;
  assign count_wr = bus.wr && (bus.addr == T8P_OFF_COUNT);
  assign cfg.om_a = st_r.ctrl_a[T8P_POS_OM_A +: 2];
  assign cfg.om_b = st_r.ctrl_a[T8P_POS_OM_B +: 2];
  assign cfg.wave = {st_r.ctrl_b[T8P_POS_WAVE_HI], st_r.ctrl_a[T8P_POS_WAVE +: 2]};
  assign cfg.cmp_a = st_r.cmp_a;
  assign cfg.cmp_b = st_r.cmp_b;

  // unused bits of the first control register never read back
  ctrl_a_gap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_r.ctrl_a[3:2] == 2'b00)
    else $error("control a unused bits not zero");

  // an overflow event always leaves the flag set, even under a clear
  ovf_set_wins_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evt.ovf |=> flags[T8P_POS_F_OVF])
    else $error("overflow event lost");

endmodule // t8p_regs

// *** rtl/t8p_chan.sv ***
// Purpose: one output compare channel, holds its wave state
// Assumes: all event inputs are already qualified by the timer tick
// Notes:   toggle_ok is tied low for a channel without toggle option

`timescale 1ns/1ps

module t8p_chan
  import t8p_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic fast,
  input wire logic pc,
  input wire logic up_count,
  input wire logic at_wrap,
  input wire logic at_top,
  input wire logic match,
  input wire logic cmp_is_top,
  input wire logic from_max,
  input wire logic toggle_ok,
  input wire logic [1:0] om,
  output logic wave
);

  typedef struct packed {
    logic wave;
  } t8p_chan_st_t;

  t8p_chan_st_t st_r; // registered wave state
  t8p_chan_st_t st_nxt; // next wave state
  logic clr_val; // level after an up-count / fast match
  logic set_val; // level after bottom / down-count match

  // ----------------------------------------------------------------
  // wave state update
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    clr_val = (om == T8P_OM_INV);
    set_val = (om == T8P_OM_NONINV);
    if (om[1] && fast) begin
      if (at_wrap) begin
        st_nxt.wave = set_val; // level at bottom
      end else if (match && !cmp_is_top) begin
        st_nxt.wave = clr_val; // match at top is ignored
      end
    end else if (om[1] && pc) begin
      if (at_top && from_max) begin
        st_nxt.wave = clr_val; // leave max with up-match result
      end else if (at_top && cmp_is_top) begin
        st_nxt.wave = set_val; // action moved to the extreme
      end else if (match) begin
        // a start above compare simply never sees the up match
        st_nxt.wave = up_count ? clr_val : set_val;
      end
    end else if (om == T8P_OM_TOGGLE && toggle_ok && (fast || pc) && match) begin
      st_nxt.wave = ~st_r.wave; // 50% duty square wave
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wave = st_r.wave;

  // fast non-inverting: wrap always drives the wave high next cycle
  fast_wrap_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fast && om == T8P_OM_NONINV && at_wrap |=> wave)
    else $error("wave not set at bottom");

  // phase correct non-inverting: ordinary up match drives low
  pc_up_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pc && om == T8P_OM_NONINV && match && up_count && !at_top |=> !wave)
    else $error("wave not cleared on up match");

  // in fast mode, toggle flips the level on every match
  toggle_flip_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    om == T8P_OM_TOGGLE && toggle_ok && fast && match |=> wave != $past(wave))
    else $error("toggle missed");

endmodule // t8p_chan

// *** dv/t8p_pin_model.sv ***
// Purpose: pad model standing on one waveform pin of the unit
// Assumes: the board holds the pin with a pull-up resistor
// Notes:   a released pin reads high, never the last driven level

`timescale 1ns/1ps

module t8p_pin_model (
  input wire logic drv,
  input wire logic oe,
  output logic pin
);
  // pad: unit value while enabled, pull-up level once released
  assign pin = oe ? drv : 1'b1;
endmodule // t8p_pin_model

// *** dv/timer8_pwm_waveform_unit_bench.sv ***
// Purpose: self-checking bench for the 8-bit pwm waveform unit
// Assumes: timer_tick held high except in the tick scenario, so the counter moves every clock
// Notes:   duty is judged by counting high pin cycles over whole periods

`timescale 1ns/1ps

module timer8_pwm_waveform_unit_bench import t8p_pkg::*;;
  // ----------------------------------------------------------------
  // stimulus, pins and tallies
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic timer_tick = 1'b1; // no prescaling
  t8p_bus_t bus = '0;
  logic dir_a = 1'b1; // pin a starts as output
  logic dir_b = 1'b1; // pin b starts as output
  logic port_a = 1'b1; // port data for pin a with no output mode
  logic [7:0] rdata;
  logic wave_a, oe_a, wave_b, oe_b, pin_a, pin_b, ovf, ma, mb;
  int n_errors = 0;
  int checks = 0;

  always #25 clk_sys = ~clk_sys;

  t8p_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .timer_tick(timer_tick), .bus(bus),
    .rdata(rdata), .dir_a(dir_a), .dir_b(dir_b), .port_a(port_a), .port_b(1'b0),
    .chan_a_wave_out(wave_a), .chan_a_wave_oe(oe_a), .chan_b_wave_out(wave_b),
    .chan_b_wave_oe(oe_b), .overflow_flag(ovf), .chan_a_match_flag(ma),
    .chan_b_match_flag(mb));
  t8p_pin_model pad_a (.drv(wave_a), .oe(oe_a), .pin(pin_a));
  t8p_pin_model pad_b (.drv(wave_b), .oe(oe_b), .pin(pin_b));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= {a, d, 2'b10};
    @(posedge clk_sys) bus <= {a, d, 2'b00};
  endtask

  // read strobe, data judged once the registered answer has landed
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys) bus <= {a, 8'h00, 2'b01};
    @(posedge clk_sys) bus <= {a, 8'h00, 2'b00};
    @(posedge clk_sys) #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // high cycles of pin a (or pin b) over len clocks
  task automatic meas(input logic sel_b, input int len, output logic [15:0] n);
    n = 16'h0000;
    repeat (len) begin
      @(posedge clk_sys) #1;
      if ((sel_b ? pin_b : pin_a) === 1'b1) n++;
    end
  endtask

  // normal mode first so the compare buffer loads at once, then the pwm mode
  task automatic run(input logic [2:0] wm, input logic [7:0] cmp, input logic [1:0] om,
      input int len, input logic [15:0] exp);
    logic [15:0] n;
    wr(T8P_OFF_CTRL_A, 8'h00);
    wr(T8P_OFF_CMP_A, cmp);
    wr(T8P_OFF_CTRL_B, {4'h0, wm[2], 3'h0});
    wr(T8P_OFF_CTRL_A, {om, 4'h0, wm[1:0]});
    repeat (1100) @(posedge clk_sys); // settle past two periods
    wr(T8P_OFF_FLAGS, 8'h07);
    meas(1'b0, len, n);
    chk(n, exp);
    chk({15'h0000, ovf}, 16'h0001);
    chk({14'h0000, ma, mb}, 16'h0003);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(T8P_OFF_CTRL_A, T8P_RST_BYTE);
    wr(T8P_OFF_CTRL_A, 8'hff);
    rd(T8P_OFF_CTRL_A, T8P_CTRL_A_MASK);
    rd(8'h24 + 8'h20, T8P_CTRL_A_MASK); // software io alias plus its bias
    rd(8'h50, 8'h00); // unmapped place reads zero
  endtask

  task automatic t_fast;
    run(T8P_WM_FAST_MAX, 8'h02, T8P_OM_NONINV, 256, 16'h0003);
    run(T8P_WM_FAST_MAX, 8'h02, T8P_OM_INV, 256, 16'h00fd);
    run(T8P_WM_FAST_MAX, 8'h00, T8P_OM_NONINV, 256, 16'h0001);
    run(T8P_WM_FAST_MAX, 8'hff, T8P_OM_NONINV, 256, 16'h0100);
  endtask

  task automatic t_pc;
    run(T8P_WM_PC_MAX, 8'h40, T8P_OM_NONINV, 510, 16'h0080);
    run(T8P_WM_PC_MAX, 8'h40, T8P_OM_INV, 510, 16'h017e);
    run(T8P_WM_PC_MAX, 8'h00, T8P_OM_NONINV, 510, 16'h0000);
    run(T8P_WM_PC_MAX, 8'hff, T8P_OM_NONINV, 510, 16'h01fe);
  endtask

  task automatic t_toggle;
    run(T8P_WM_FAST_CMP, 8'h00, T8P_OM_TOGGLE, 256, 16'h0080);
    run(T8P_WM_PC_CMP, 8'h40, T8P_OM_TOGGLE, 256, 16'h0080);
  endtask

  // released pin shows the pull-up, not the wave; no output mode shows port data
  task automatic t_dir;
    logic [15:0] n;
    @(posedge clk_sys) begin
      dir_a <= 1'b0;
      dir_b <= 1'b0;
    end
    meas(1'b0, 256, n);
    chk(n, 16'h0100);
    chk({15'h0000, oe_a}, 16'h0000);
    chk({15'h0000, oe_b}, 16'h0000);
    @(posedge clk_sys) begin
      dir_a <= 1'b1;
      dir_b <= 1'b1;
    end
    wr(T8P_OFF_CTRL_A, 8'h00);
    @(posedge clk_sys) port_a <= 1'b0;
    meas(1'b0, 8, n);
    chk(n, 16'h0000);
    @(posedge clk_sys) port_a <= 1'b1;
    meas(1'b0, 8, n);
    chk(n, 16'h0008);
  endtask

  // channel b: plain pwm, match at top ignored, mode 1 never toggles
  task automatic t_chan_b;
    logic [15:0] n;
    wr(T8P_OFF_CTRL_A, 8'h00);
    wr(T8P_OFF_CMP_B, 8'h10);
    wr(T8P_OFF_CTRL_B, 8'h00);
    wr(T8P_OFF_CTRL_A, {2'b00, T8P_OM_NONINV, 4'h3});
    repeat (600) @(posedge clk_sys);
    meas(1'b1, 256, n);
    chk(n, 16'h0011);
    wr(T8P_OFF_CMP_B, 8'hff);
    repeat (600) @(posedge clk_sys);
    meas(1'b1, 256, n);
    chk(n, 16'h0100);
    wr(T8P_OFF_CTRL_A, {2'b00, T8P_OM_TOGGLE, 4'h3});
    wr(T8P_OFF_CMP_B, 8'h05);
    wr(T8P_OFF_CTRL_B, 8'h08);
    repeat (600) @(posedge clk_sys);
    meas(1'b1, 256, n);
    chk(n, 16'h0100);
  endtask

  // a held-off tick freezes a freshly written count
  task automatic t_tick;
    @(posedge clk_sys) timer_tick <= 1'b0;
    wr(T8P_OFF_COUNT, 8'h5a);
    repeat (20) @(posedge clk_sys);
    rd(T8P_OFF_COUNT, 8'h5a);
    @(posedge clk_sys) timer_tick <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // verdict, main sequence, watchdog
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_fast();
    t_pc();
    t_toggle();
    t_dir();
    t_chan_b();
    t_tick();
    summarize();
  end

  // about twice the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end
endmodule // timer8_pwm_waveform_unit_bench
